//--- rtl/adc_host.v
`include "adc_host_map.vh"
module adc_host #(
	parameter N_CHAN       = 8,
	parameter ACQ_NS       = `ACQ_NS,
	parameter WR_PULSE_NS  = `WR_PULSE_NS,
	parameter WR_TO_RD_NS  = `WR_TO_RD_NS,
	parameter WAKE_NS      = `WAKE_NS,
	parameter PWR_UP_NS    = `PWR_UP_NS,
	parameter SWITCH_ON_NS = `SWITCH_ON_NS,
	parameter TIMEOUT_CYC  = `TIMEOUT_CYC
) (
	input  wire        clock,
	input  wire        rst_n,
	input  wire [3:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	output reg         cs_n,
	output reg         rd_n,
	output reg         wr_out,
	output reg         wr_oe,
	input  wire        wr_rdy_in,
	input  wire        int_n,
	input  wire [7:0]  data_in,
	output reg         mode,
	output reg         chan_sel_bit0,
	output reg         chan_sel_bit1,
	output reg         chan_sel_bit2,
	output reg         sleep_n,
	output reg         ref_on
);
	// full-width cycle counts, cut to the timer width on purpose below
	localparam        ACQ_FULL   = (ACQ_NS * `CLK_MHZ + 999) / 1000;
	localparam        WR_FULL    = (WR_PULSE_NS * `CLK_MHZ + 999) / 1000;
	localparam        WTR_FULL   = (WR_TO_RD_NS * `CLK_MHZ + 999) / 1000;
	localparam        ACC_FULL   = ((`RBD_TOTAL_NS - WR_PULSE_NS - WR_TO_RD_NS) * `CLK_MHZ
		+ 999) / 1000;
	localparam        WAKE_FULL  = (WAKE_NS * `CLK_MHZ + 999) / 1000;
	localparam        REFUP_FULL = ((PWR_UP_NS + SWITCH_ON_NS) * `CLK_MHZ + 999) / 1000;
	localparam        TMO_FULL   = TIMEOUT_CYC;
	localparam [11:0] ACQ_CYC    = ACQ_FULL[11:0];
	localparam [11:0] WR_CYC     = WR_FULL[11:0];
	localparam [11:0] WTR_CYC    = WTR_FULL[11:0];
	localparam [11:0] ACC_CYC    = ACC_FULL[11:0];
	localparam [11:0] WAKE_CYC   = WAKE_FULL[11:0];
	localparam [11:0] REFUP_CYC  = REFUP_FULL[11:0];
	localparam [11:0] TMO_CYC    = TMO_FULL[11:0];

	localparam [7:0] S_IDLE = 8'h01;
	localparam [7:0] S_RDMD = 8'h02;
	localparam [7:0] S_WRLO = 8'h04;
	localparam [7:0] S_WINT = 8'h08;
	localparam [7:0] S_WTRD = 8'h10;
	localparam [7:0] S_RDLO = 8'h20;
	localparam [7:0] S_REL  = 8'h40;

	reg  [9:0]  sync1;
	reg  [9:0]  sync2;
	reg  [7:0]  state;
	reg  [11:0] timer;
	reg  [11:0] settle;
	reg  [11:0] settle_req;
	reg  [2:0]  chan_cfg;
	reg         mode_cfg;
	reg  [1:0]  seq_cfg;
	reg  [1:0]  seq_run;
	reg         pending;
	reg         done;
	reg         timeout;
	reg         init_pending;
	reg  [7:0]  result;
	reg  [2:0]  result_chan;
	reg         ack;
	reg         int_prev;
	wire [7:0]  data_s  = sync2[9:2];
	wire        int_s_n = sync2[1];
	// only a fall seen during this conversion counts; a flag left low by a
	// pipelined pulse would otherwise end the next conversion at once
	wire        int_fell = int_prev & ~int_s_n;
	wire        acc     = (read | write) & ack;
	wire        wr_ctrl = write & acc & (address[3:2] == `REG_CTRL);
	// flags clear at the edge that copies them into readdata, so none is lost
	wire        rd_stat = read & ~ack & (address[3:2] == `REG_STATUS);
	wire [2:0]  chan_mask = (N_CHAN == 4) ? 3'h3 : 3'h7;
	wire        idle    = state == S_IDLE;
	wire        pins_ok = (mode == mode_cfg) &
		({chan_sel_bit2, chan_sel_bit1, chan_sel_bit0} == (chan_cfg & chan_mask));
	wire        go      = idle & pending & sleep_n & (settle == 12'h000) & pins_ok;
	wire        finish  = state == S_REL;

	// both pins come from the device's own timing, so both pass two flops
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			// flag pins reset to their idle high level so no false fall follows reset
			sync1    <= 10'h003;
			sync2    <= 10'h003;
			int_prev <= 1'b1;
		end else begin
			sync1    <= {data_in, int_n, wr_rdy_in};
			sync2    <= sync1;
			int_prev <= int_s_n;
		end
	end

	// one-cycle wait state on every access; answer lands on the second edge
	assign waitrequest = (read | write) & ~ack;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ack      <= 1'b0;
			readdata <= 32'h00000000;
		end else begin
			ack <= (read | write) & ~ack;
			if (read & ~ack) begin
				case (address[3:2])
				`REG_CTRL:   readdata <= {23'h000000, ref_on, sleep_n, seq_cfg, mode_cfg,
					chan_cfg, 1'b0};
				`REG_STATUS: readdata <= {27'h0000000, pending, init_pending, timeout, done,
					~idle};
				`REG_DATA:   readdata <= {21'h000000, result_chan, result};
				default:     readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// settling takes the longest outstanding wait so a short one never cuts a long one
	always @* begin
		settle_req = 12'h000;
		if (finish)
			settle_req = ACQ_CYC;
		if (idle && ({chan_sel_bit2, chan_sel_bit1, chan_sel_bit0} != (chan_cfg & chan_mask)))
			settle_req = ACQ_CYC;
		if (wr_ctrl && writedata[`CTRL_REF_ON] && !ref_on)
			settle_req = REFUP_CYC;
		if (wr_ctrl && writedata[`CTRL_WAKE] && !sleep_n)
			settle_req = (WAKE_CYC > settle_req) ? WAKE_CYC : settle_req;
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chan_cfg      <= 3'h0;
			mode_cfg      <= 1'b0;
			seq_cfg       <= `SEQ_INTERNAL;
			sleep_n       <= 1'b0;
			ref_on        <= 1'b0;
			pending       <= 1'b0;
			done          <= 1'b0;
			timeout       <= 1'b0;
			init_pending  <= 1'b1;
			settle        <= 12'h000;
			mode          <= 1'b0;
			chan_sel_bit0 <= 1'b0;
			chan_sel_bit1 <= 1'b0;
			chan_sel_bit2 <= 1'b0;
		end else begin
			if (settle_req > settle)
				settle <= settle_req;
			else if (settle != 12'h000)
				settle <= settle - 12'h001;
			if (wr_ctrl) begin
				chan_cfg <= writedata[`CTRL_CHAN_HI:`CTRL_CHAN_LO];
				mode_cfg <= writedata[`CTRL_MODE];
				seq_cfg  <= writedata[`CTRL_SEQ_HI:`CTRL_SEQ_LO];
				sleep_n  <= writedata[`CTRL_WAKE];
				ref_on   <= writedata[`CTRL_REF_ON];
			end
			if (wr_ctrl && !writedata[`CTRL_WAKE])
				init_pending <= 1'b1;
			else if (finish && init_pending)
				init_pending <= 1'b0;
			// a start written while a conversion runs is dropped
			if (wr_ctrl && writedata[`CTRL_START] && idle && !pending)
				pending <= 1'b1;
			else if (finish && !init_pending)
				pending <= 1'b0;
			// hardware set wins over the clear-on-read of status
			done    <= (finish & ~init_pending) | (done & ~rd_stat);
			timeout <= ((state == S_WINT || state == S_RDMD) && timer == 12'h000 && !int_fell)
				| (timeout & ~rd_stat);
			// pins only move between conversions, and a start waits until they match
			if (idle) begin
				mode          <= mode_cfg;
				chan_sel_bit0 <= chan_cfg[0] & chan_mask[0];
				chan_sel_bit1 <= chan_cfg[1] & chan_mask[1];
				chan_sel_bit2 <= chan_cfg[2] & chan_mask[2];
			end
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state       <= S_IDLE;
			timer       <= 12'h000;
			seq_run     <= `SEQ_INTERNAL;
			cs_n        <= 1'b1;
			rd_n        <= 1'b1;
			wr_out      <= 1'b1;
			wr_oe       <= 1'b0;
			result      <= 8'h00;
			result_chan <= 3'h0;
		end else begin
			// in read mode the shared pin is the device's ready output, left undriven
			wr_oe <= idle ? mode_cfg : mode;
			if (timer != 12'h000)
				timer <= timer - 12'h001;
			case (state)
			S_IDLE: begin
				if (go) begin
					seq_run <= seq_cfg;
					cs_n    <= 1'b0;
					if (!mode) begin
						rd_n  <= 1'b0;
						timer <= TMO_CYC;
						state <= S_RDMD;
					end else begin
						wr_out <= 1'b0;
						rd_n   <= (seq_cfg == `SEQ_PIPELINED) ? 1'b0 : 1'b1;
						timer  <= WR_CYC;
						state  <= S_WRLO;
					end
				end
			end
			S_RDMD: begin
				// read strobe held low as a wait state until the end flag falls
				if (int_fell || timer == 12'h000) begin
					timer <= ACC_CYC;
					state <= S_RDLO;
				end
			end
			S_WRLO: begin
				if (timer == 12'h000) begin
					wr_out <= 1'b1;
					if (seq_run == `SEQ_PIPELINED) begin
						result <= data_s;
						state  <= S_REL;
					end else if (seq_run == `SEQ_EARLY_RD) begin
						timer <= WTR_CYC;
						state <= S_WTRD;
					end else begin
						timer <= TMO_CYC;
						state <= S_WINT;
					end
				end
			end
			S_WINT: begin
				if (int_fell || timer == 12'h000) begin
					rd_n  <= 1'b0;
					timer <= ACC_CYC;
					state <= S_RDLO;
				end
			end
			S_WTRD: begin
				// reading before the internal delay forces the lower half to finish
				if (timer == 12'h000) begin
					rd_n  <= 1'b0;
					timer <= ACC_CYC;
					state <= S_RDLO;
				end
			end
			S_RDLO: begin
				if (timer == 12'h000) begin
					// data bus is only driven while both strobes are low
					result <= data_s;
					state  <= S_REL;
				end
			end
			S_REL: begin
				rd_n        <= 1'b1;
				cs_n        <= 1'b1;
				wr_out      <= 1'b1;
				result_chan <= {chan_sel_bit2, chan_sel_bit1, chan_sel_bit0};
				state       <= S_IDLE;
			end
			default: begin
				state <= S_IDLE;
				cs_n  <= 1'b1;
				rd_n  <= 1'b1;
			end
			endcase
		end
	end
endmodule

//--- rtl/adc_host_map.vh
`ifndef ADC_HOST_MAP_VH
`define ADC_HOST_MAP_VH
// Functional notes
// - inputs track before conversion; host waits acquisition time before next start
// - read mode: host starts conversion with chip select and read strobe low together
// - host may hold read strobe low as a wait state until data is valid
// - host waits acquisition time after end flag falls before next write strobe; pipelined mode counts it from release, not from the flag
// - internal delay: host waits for end flag then reads; strobe rise clears flag
// - host may read after write rises before delay ends, forcing completion
// - after reference switch-on, host waits power-up plus switch turn-on time
// - after power-up host performs one conversion and discards the result
`define CLK_MHZ        200
`define REG_CTRL       2'h0
`define REG_STATUS     2'h1
`define REG_DATA       2'h2
`define CTRL_START     0
`define CTRL_CHAN_LO   1
`define CTRL_CHAN_HI   3
`define CTRL_MODE      4
`define CTRL_SEQ_LO    5
`define CTRL_SEQ_HI    6
`define CTRL_WAKE      7
`define CTRL_REF_ON    8
`define ST_BUSY        0
`define ST_DONE        1
`define ST_TIMEOUT     2
`define ST_INIT        3
`define ST_PENDING     4
`define SEQ_INTERNAL   2'h0
`define SEQ_EARLY_RD   2'h1
`define SEQ_PIPELINED  2'h2
`define ACQ_NS         450
`define WR_PULSE_NS    600
`define WR_TO_RD_NS    800
`define RBD_TOTAL_NS   1800
`define WAKE_NS        900
`define PWR_UP_NS      900
`define SWITCH_ON_NS   100
`define TIMEOUT_CYC    2000
`endif

//--- bench/adc_host_chk.sv
module adc_host_chk (
	input wire	clock,
	input wire	rst_n,
	input wire	cs_n,
	input wire	rd_n,
	input wire	wr_out,
	input wire	wr_oe,
	input wire	int_n,
	input wire	mode,
	input wire	chan_sel_bit0,
	input wire	chan_sel_bit1,
	input wire	chan_sel_bit2,
	input wire	sleep_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [7:0]	hi_cnt;
	logic [7:0]	lo_cnt;
	// saturating run lengths of a released bus and of a low write strobe
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n) begin
			hi_cnt <= 8'h00;
			lo_cnt <= 8'h00;
		end else begin
			hi_cnt <= !cs_n ? 8'h00 : hi_cnt + {7'h0, hi_cnt != 8'hff};
			lo_cnt <= wr_out ? 8'h00 : lo_cnt + {7'h0, lo_cnt != 8'hff};
		end
	sequence s_start; $fell(cs_n) && !mode; endsequence
	sequence s_release; ##[1:100] $rose(cs_n); endsequence
	a_start_both: assert property (s_start |-> $fell(rd_n))
		else $error("start without read strobe");
	a_read_held: assert property (!mode && !cs_n |-> !rd_n)
		else $error("read strobe dropped early");
	a_read_end: assert property ($fell(int_n) && !mode && !cs_n |-> s_release)
		else $error("no release after end flag");
	a_rd_cs: assert property (!rd_n |-> !cs_n)
		else $error("read strobe without select");
	a_wr_cs: assert property (wr_oe && !wr_out |-> !cs_n)
		else $error("write strobe without select");
	a_pin_dir: assert property (wr_oe |-> mode)
		else $error("ready pin driven in read mode");
	a_mode_hold: assert property (!cs_n |-> $stable(mode))
		else $error("mode moved in conversion");
	a_chan_hold: assert property (!cs_n && !$past(cs_n) |->
		$stable({chan_sel_bit2, chan_sel_bit1, chan_sel_bit0}))
		else $error("channel moved in conversion");
	a_awake_start: assert property (!cs_n |-> sleep_n)
		else $error("select while asleep");
	a_acq_gap: assert property ($fell(cs_n) |-> hi_cnt >= 8'h5a)
		else $error("acquisition gap short");
	a_wr_pulse: assert property ($rose(wr_out) && wr_oe |-> lo_cnt >= 8'h78)
		else $error("write pulse short");
endmodule
bind adc_host adc_host_chk chk_u (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
	.wr_out(wr_out), .wr_oe(wr_oe), .int_n(int_n), .mode(mode), .chan_sel_bit0(chan_sel_bit0),
	.chan_sel_bit1(chan_sel_bit1), .chan_sel_bit2(chan_sel_bit2), .sleep_n(sleep_n));

//--- bench/adc_model.sv
module adc_model #(parameter int CONV_NS = 1200, parameter int INTL_NS = 900) (
	input wire		cs_n,
	input wire		rd_n,
	input wire		wr_out,
	input wire		wr_oe,
	input wire		mode,
	input wire		chan_sel_bit0,
	input wire		chan_sel_bit1,
	input wire		chan_sel_bit2,
	input wire		sleep_n,
	output logic		int_n,
	output wire [7:0]	data_in,
	output wire		wr_rdy_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic		busy = 0;
	logic		rdy_low = 0;
	logic [7:0]	res = 8'h00;
	logic [7:0]	val;
	logic [2:0]	sel;
	wire		strobe = ~cs_n & (mode ? wr_oe & ~wr_out : ~rd_n);
	initial int_n = 1;
	task automatic finish;
		if (busy) begin
			res[3:0] = val[3:0];
			if (!mode)
				res = val;
			int_n = 0;
			busy = 0;
			rdy_low = 0;
		end
	endtask
	always @(posedge strobe)
		if (!busy && sleep_n) begin
			sel = {chan_sel_bit2, chan_sel_bit1, chan_sel_bit0};
			val = sel == 3'd7 ? 8'hff : {1'b0, sel, 1'b0, sel};
			busy = 1;
			rdy_low = !mode;
			if (!mode)
				#CONV_NS finish();
		end
	always @(posedge wr_out)
		if (busy && mode) begin
			res[7:4] = val[7:4];
			#INTL_NS finish();
		end
	always @(negedge rd_n)
		if (busy && mode && wr_out && !cs_n)
			#50 finish();
	always @(posedge cs_n or posedge rd_n)
		int_n = 1;
	// undriven data bus shows inverted bits so a stale sample cannot match
	assign data_in = !cs_n && !rd_n ? res : ~res;
	assign wr_rdy_in = wr_oe ? wr_out : !rdy_low;
endmodule

//--- bench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic		clock = 0;
	logic		rst_n = 0;
	logic		read = 0;
	logic		write = 0;
	logic [3:0]	address = 4'h0;
	logic [31:0]	writedata = 32'h0;
	logic [31:0]	rdv;
	wire [31:0]	readdata;
	wire [7:0]	data_in;
	wire		waitrequest, cs_n, rd_n, wr_out, wr_oe, wr_rdy_in, int_n, mode;
	wire		chan_sel_bit0, chan_sel_bit1, chan_sel_bit2, sleep_n, ref_on;
	int		fails = 0;
	int		n_compared = 0;
	int		cyc = 0;
	initial forever #2.5 clock = ~clock;
	adc_host dut_u (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .cs_n(cs_n), .rd_n(rd_n), .wr_out(wr_out), .wr_oe(wr_oe),
		.wr_rdy_in(wr_rdy_in), .int_n(int_n), .data_in(data_in), .mode(mode),
		.chan_sel_bit0(chan_sel_bit0), .chan_sel_bit1(chan_sel_bit1),
		.chan_sel_bit2(chan_sel_bit2), .sleep_n(sleep_n), .ref_on(ref_on));
	adc_model dev_u (.cs_n(cs_n), .rd_n(rd_n), .wr_out(wr_out), .wr_oe(wr_oe), .mode(mode),
		.chan_sel_bit0(chan_sel_bit0), .chan_sel_bit1(chan_sel_bit1),
		.chan_sel_bit2(chan_sel_bit2), .sleep_n(sleep_n), .int_n(int_n),
		.data_in(data_in), .wr_rdy_in(wr_rdy_in));
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 80000) begin
			fails++;
			end_sim;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// request stands until the rising edge that sees waitrequest low; data taken there
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		@(posedge clock);
		while (waitrequest !== 1'b0)
			@(posedge clock);
		rdv = readdata;
		read <= 0;
		write <= 0;
	endtask
	function automatic [31:0] expv(input logic [2:0] c);
		expv = {21'h0, c, c == 3'd7 ? 8'hff : {1'b0, c, 1'b0, c}};
	endfunction
	// reading status clears done, so the poll itself consumes it
	task automatic conv(input logic [2:0] ch, input logic md, input logic [1:0] sq);
		bus(1, 4'h0, {23'h0, 2'b11, sq, md, ch, 1'b1});
		rdv = 0;
		repeat (2000)
			if (rdv[1] !== 1'b1)
				bus(0, 4'h4, 0);
		bus(0, 4'h8, 0);
	endtask
	task automatic t_reset;
		chk({26'h0, cs_n, rd_n, wr_oe, mode, sleep_n, ref_on}, 32'h30);
		bus(0, 4'h4, 0);
		chk(rdv & 32'h8, 32'h8);
		bus(0, 4'hc, 0);
		chk(rdv, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_read_chan;
		for (int c = 0; c < 8; c++) begin
			conv(c[2:0], 0, 2'h0);
			chk(rdv & 32'h7ff, expv(c[2:0]));
		end
		bus(0, 4'h4, 0);
		chk(rdv & 32'h8, 32'h0);
		chk({31'h0, ref_on}, 32'h1);
		$display("read mode test done");
	endtask
	task automatic t_write_read;
		conv(3'd3, 1, 2'h0);
		chk(rdv & 32'h7ff, expv(3'd3));
		conv(3'd5, 1, 2'h1);
		chk(rdv & 32'h7ff, expv(3'd5));
		conv(3'd6, 1, 2'h2);
		// data belongs to the previous conversion, the channel field to this one
		chk(rdv & 32'h7ff, 32'h655);
		repeat (300) @(posedge clock);
		$display("write-read test done");
	endtask
	task automatic t_refuse;
		bus(1, 4'h0, 32'h185);
		bus(1, 4'h0, 32'h185);
		conv(3'd2, 0, 2'h0);
		chk(rdv & 32'h7ff, expv(3'd2));
		bus(0, 4'h4, 0);
		chk(rdv & 32'h1f, 32'h0);
		$display("refusal test done");
	endtask
	task automatic t_sleep;
		bus(1, 4'h0, 32'h0);
		repeat (2) @(posedge clock);
		chk({31'h0, sleep_n}, 32'h0);
		bus(0, 4'h4, 0);
		chk(rdv & 32'h8, 32'h8);
		$display("sleep test done");
	endtask
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1;
		t_reset;
		t_read_chan;
		t_write_read;
		t_refuse;
		t_sleep;
		end_sim;
	end
endmodule
